// File: logic/swr_fifo2.sv
`timescale 1ns/1ps
module swr_fifo2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// filling side
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// draining side
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	if (DEPTH != 2) begin : g_bad_depth
		$error("swr_fifo2 supports only DEPTH 2");
	end

	logic [W-1:0] tail_reg;
	logic tail_v_reg;
	logic push;
	logic pop;

	// head sits on the outputs so the top sees flop-driven data
	assign in_ready = !tail_v_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_data <= '0;
			out_valid <= 1'b0;
			tail_reg <= '0;
			tail_v_reg <= 1'b0;
		end else if (pop) begin
			out_data <= tail_v_reg ? tail_reg : in_data;
			out_valid <= tail_v_reg || push;
			tail_v_reg <= 1'b0;
		end else if (push) begin
			if (!out_valid) begin
				out_data <= in_data;
				out_valid <= 1'b1;
			end else begin
				tail_reg <= in_data;
				tail_v_reg <= 1'b1;
			end
		end
	end

endmodule // swr_fifo2

// File: logic/swr_link.sv
`timescale 1ns/1ps
// Function
// R1: access order is reset, network command, memory function, then data
// R2: master reset pulse, then slave presence pulse shows readiness
// R3: idle line is high; long low (16/120 us) counts as reset
// R4: line driven only by open-drain pull-down, wired-AND with others
// R5: every slot starts at master falling edge; bit timing syncs to it
// R6: regular or overdrive rate, chosen by the overdrive flag
// R7: after presence take eight-bit network command, decode six commands
// R8: 33h sends 64-bit identity: family, serial, check byte
// R9: 55h takes 64 bits; exact match proceeds, else wait for reset
// R10: CCh goes straight to memory function command
// R11: F0h per bit: send bit, send complement, take master bit
// R12: 3Ch sets overdrive, skips identity; long reset clears it
// R13: a device already in overdrive keeps it through short reset
// R14: 69h takes 64 bits at overdrive; match sets overdrive, proceeds
// R15: failed 69h keeps prior speed and waits for reset
// R16: write scratchpad framing: addresses, data, inverted CRC16 back
// R17: read scratchpad framing: addresses, status byte, then data
// R18: copy scratchpad framing: three authorization bytes, then response
// R19: read memory plus counter framing: page, counter, tamper, CRC
// R20: presence waits 15-60 us after rise, lasts 60-240 us
// R21: reset of 480 us clears overdrive; short one keeps it
// R22: write slots sampled after delay; read zero held low for delay
// R23: all bytes travel least significant bit first
// R24: search drops out until reset when master bit differs
module swr_link import swr_pkg::*; #(
	parameter int unsigned RST_REG_CYC = RST_REG_CYC_DEF,
	parameter int unsigned RST_LONG_CYC = RST_LONG_CYC_DEF,
	parameter int unsigned PDL_REG_CYC = PDL_REG_CYC_DEF,
	parameter logic [7:0] ID_FAMILY = 8'h5E, // arbitrary value
	parameter logic [47:0] ID_SERIAL = 48'h0123_4567_89AB, // arbitrary value
	parameter logic [7:0] ID_CHECK = 8'h3D // arbitrary value
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// shared data line
	input wire logic dq_in,
	output logic dq_out,
	output logic dq_oe,
	// status
	output logic overdrive_flag,
	output logic link_reset,
	output logic func_active,
	output logic rx_overrun,
	// received function bytes
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// bytes to send
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_taken
);

	if (RST_LONG_CYC <= RST_REG_CYC || RST_LONG_CYC >= (1 << CNT_W) || PDL_REG_CYC < 2
		|| RST_REG_CYC <= SMP_REG_CYC) begin : g_bad_param
		$error("swr_link timing parameters out of range");
	end

	localparam logic [ID_BITS-1:0] ROM_ID = {ID_CHECK, ID_SERIAL, ID_FAMILY};
	localparam logic [CNT_W-1:0] C_RST_REG = CNT_W'(RST_REG_CYC);
	localparam logic [CNT_W-1:0] C_RST_OD = CNT_W'(RST_OD_CYC);
	localparam logic [CNT_W-1:0] C_RST_LONG = CNT_W'(RST_LONG_CYC);
	localparam logic [CNT_W-1:0] C_PDH_REG = CNT_W'(PDH_REG_CYC);
	localparam logic [CNT_W-1:0] C_PDH_OD = CNT_W'(PDH_OD_CYC);
	localparam logic [CNT_W-1:0] C_PDL_REG = CNT_W'(PDL_REG_CYC);
	localparam logic [CNT_W-1:0] C_PDL_OD = CNT_W'(PDL_OD_CYC);
	localparam logic [CNT_W-1:0] C_SMP_REG = CNT_W'(SMP_REG_CYC);
	localparam logic [CNT_W-1:0] C_SMP_OD = CNT_W'(SMP_OD_CYC);

	swr_state_t state_reg;
	logic dq_prev_reg;
	logic [CNT_W-1:0] low_cnt_reg;
	logic [CNT_W-1:0] tmr_reg;
	logic in_slot_reg;
	logic [BIT_W-1:0] bit_cnt_reg;
	logic [1:0] phase_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_shift_reg;
	logic tx_busy_reg;
	logic match_ok_reg;
	logic od_match_reg;
	logic rx_push_reg;
	logic [7:0] rx_byte_reg;
	logic fifo_in_ready;
	logic rst_fast_reg;

	logic fast;
	logic fall_evt;
	logic rise_evt;
	logic reset_rise;
	logic long_rst;
	logic bit_evt;
	logic rx_bit;
	logic id_bit;
	logic send_now;
	logic send_bit;
	logic [7:0] new_byte;
	logic last_id_bit;
	logic [CNT_W-1:0] c_rst;
	logic [CNT_W-1:0] c_pdh;
	logic [CNT_W-1:0] c_pdl;
	logic [CNT_W-1:0] c_smp;

	// ----------------------------------------------------------------
	// line events and timing selection
	// ----------------------------------------------------------------
	// overdrive match bits already run fast before the flag is set
	assign fast = overdrive_flag || (state_reg == ST_MATCH && od_match_reg); // see R6 see R14
	// threshold follows the speed in force when the low began, so the
	// slow last bit of a speed-changing command is not taken for a reset
	assign c_rst = rst_fast_reg ? C_RST_OD : C_RST_REG; // see R3
	assign c_pdh = fast ? C_PDH_OD : C_PDH_REG;
	assign c_pdl = fast ? C_PDL_OD : C_PDL_REG;
	assign c_smp = fast ? C_SMP_OD : C_SMP_REG;

	// our own pull-down must not look like a master edge
	assign fall_evt = dq_prev_reg && !dq_in && !dq_oe; // see R5
	assign rise_evt = !dq_prev_reg && dq_in;
	assign reset_rise = rise_evt && (low_cnt_reg >= c_rst); // see R2 see R3
	assign long_rst = low_cnt_reg >= C_RST_LONG;
	assign bit_evt = in_slot_reg && (tmr_reg == c_smp) && !reset_rise; // see R22
	assign rx_bit = dq_in;
	assign id_bit = ROM_ID[bit_cnt_reg[5:0]];
	assign last_id_bit = bit_cnt_reg == BIT_W'(ID_BITS - 1);
	assign new_byte = {rx_bit, shift_reg[7:1]}; // see R23

	always_comb begin
		send_now = 1'b0;
		send_bit = 1'b1;
		case (state_reg)
			ST_READ_ID: begin
				send_now = 1'b1;
				send_bit = id_bit; // see R8
			end
			ST_SEARCH: begin
				send_now = (phase_reg != 2'h2);
				send_bit = (phase_reg == 2'h0) ? id_bit : !id_bit; // see R11
			end
			ST_FUNC: begin
				send_now = tx_busy_reg;
				send_bit = tx_shift_reg[0];
			end
			default: begin
				send_now = 1'b0;
				send_bit = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// low-time measurement
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dq_prev_reg <= 1'b1;
			low_cnt_reg <= '0;
			rst_fast_reg <= 1'b0;
		end else begin
			dq_prev_reg <= dq_in;
			if (dq_prev_reg && !dq_in)
				rst_fast_reg <= overdrive_flag; // see R3
			if (dq_in || dq_oe)
				low_cnt_reg <= '0;
			else if (low_cnt_reg != '1)
				low_cnt_reg <= low_cnt_reg + CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// slot and presence timer, line drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_reg <= '0;
			in_slot_reg <= 1'b0;
			dq_oe <= 1'b0;
			dq_out <= 1'b0;
		end else begin
			dq_out <= 1'b0; // see R4
			if (reset_rise || fall_evt || (state_reg == ST_PDH && tmr_reg == c_pdh))
				tmr_reg <= '0;
			else if (tmr_reg != '1)
				tmr_reg <= tmr_reg + CNT_W'(1);
			if (reset_rise) begin
				in_slot_reg <= 1'b0;
				dq_oe <= 1'b0;
			end else if (state_reg == ST_PDH && tmr_reg == c_pdh) begin
				dq_oe <= 1'b1; // see R20
			end else if (state_reg == ST_PDL) begin
				if (tmr_reg == c_pdl)
					dq_oe <= 1'b0;
			end else if (fall_evt && state_reg >= ST_CMD) begin
				in_slot_reg <= 1'b1;
				dq_oe <= send_now && !send_bit; // see R22 see R4
			end else if (bit_evt) begin
				in_slot_reg <= 1'b0;
				dq_oe <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// overdrive flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			overdrive_flag <= 1'b0;
		else if (reset_rise && long_rst)
			overdrive_flag <= 1'b0; // see R21 see R12
		else if (state_reg == ST_CMD && bit_evt && bit_cnt_reg == BIT_W'(7) && new_byte == CMD_OD_SKIP)
			overdrive_flag <= 1'b1; // see R12
		else if (state_reg == ST_MATCH && bit_evt && last_id_bit && od_match_reg
			&& match_ok_reg && rx_bit == id_bit)
			overdrive_flag <= 1'b1; // see R14
	end

	// ----------------------------------------------------------------
	// network protocol
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_DEAD;
			bit_cnt_reg <= '0;
			phase_reg <= 2'h0;
			shift_reg <= 8'h00;
			match_ok_reg <= 1'b0;
			od_match_reg <= 1'b0;
		end else if (reset_rise) begin
			state_reg <= ST_PDH; // see R2 see R13
			bit_cnt_reg <= '0;
			phase_reg <= 2'h0;
			od_match_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_PDH: begin
					if (tmr_reg == c_pdh)
						state_reg <= ST_PDL;
				end
				ST_PDL: begin
					if (tmr_reg == c_pdl)
						state_reg <= ST_CMD; // see R1
				end
				ST_CMD: begin
					if (bit_evt) begin
						shift_reg <= new_byte;
						bit_cnt_reg <= bit_cnt_reg + BIT_W'(1);
						if (bit_cnt_reg == BIT_W'(7)) begin
							bit_cnt_reg <= '0;
							match_ok_reg <= 1'b1;
							case (new_byte) // see R7
								CMD_READ_ID: state_reg <= ST_READ_ID;
								CMD_MATCH: state_reg <= ST_MATCH;
								CMD_SKIP: state_reg <= ST_FUNC; // see R10
								CMD_SEARCH: state_reg <= ST_SEARCH;
								CMD_OD_SKIP: state_reg <= ST_FUNC;
								CMD_OD_MATCH: begin
									state_reg <= ST_MATCH;
									od_match_reg <= 1'b1;
								end
								default: state_reg <= ST_DEAD;
							endcase
						end
					end
				end
				ST_READ_ID: begin
					if (bit_evt) begin
						bit_cnt_reg <= last_id_bit ? '0 : bit_cnt_reg + BIT_W'(1);
						if (last_id_bit)
							state_reg <= ST_FUNC; // see R8
					end
				end
				ST_MATCH: begin
					if (bit_evt) begin
						match_ok_reg <= match_ok_reg && (rx_bit == id_bit);
						bit_cnt_reg <= last_id_bit ? '0 : bit_cnt_reg + BIT_W'(1);
						if (last_id_bit) begin
							od_match_reg <= 1'b0;
							// a miss leaves the flag as it was
							state_reg <= (match_ok_reg && rx_bit == id_bit) ? ST_FUNC : ST_DEAD; // see R9 see R15
						end
					end
				end
				ST_SEARCH: begin
					if (bit_evt) begin
						if (phase_reg != 2'h2) begin
							phase_reg <= phase_reg + 2'h1; // see R11
						end else if (rx_bit != id_bit) begin
							state_reg <= ST_DEAD; // see R24
						end else begin
							phase_reg <= 2'h0;
							bit_cnt_reg <= last_id_bit ? '0 : bit_cnt_reg + BIT_W'(1);
							if (last_id_bit)
								state_reg <= ST_FUNC;
						end
					end
				end
				ST_FUNC: begin
					// function bytes pass both ways; meaning lives outside
					if (bit_evt) begin
						if (!tx_busy_reg)
							shift_reg <= new_byte; // see R23
						bit_cnt_reg <= {4'h0, bit_cnt_reg[2:0] + 3'h1};
					end
				end
				default: state_reg <= ST_DEAD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// function byte transport
	// ----------------------------------------------------------------
	// a byte is only taken between slots so a half-sent byte never mixes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_shift_reg <= 8'hFF;
			tx_busy_reg <= 1'b0;
			tx_taken <= 1'b0;
			rx_push_reg <= 1'b0;
			rx_byte_reg <= 8'h00;
			func_active <= 1'b0;
			link_reset <= 1'b0;
		end else begin
			tx_taken <= 1'b0;
			rx_push_reg <= 1'b0;
			link_reset <= reset_rise;
			func_active <= (state_reg == ST_FUNC) && !reset_rise; // see R1
			if (reset_rise) begin
				tx_busy_reg <= 1'b0;
			end else if (state_reg == ST_FUNC) begin
				if (!tx_busy_reg && !in_slot_reg && tx_valid && bit_cnt_reg[2:0] == 3'h0) begin
					tx_shift_reg <= tx_data; // see R17 see R19
					tx_busy_reg <= 1'b1;
					tx_taken <= 1'b1;
				end else if (bit_evt && tx_busy_reg) begin
					tx_shift_reg <= {1'b1, tx_shift_reg[7:1]}; // see R23
					if (bit_cnt_reg[2:0] == 3'h7)
						tx_busy_reg <= 1'b0;
				end else if (bit_evt && bit_cnt_reg[2:0] == 3'h7) begin
					rx_byte_reg <= new_byte; // see R16 see R18
					rx_push_reg <= 1'b1;
				end
			end
		end
	end

	// set wins over the clear at a reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rx_overrun <= 1'b0;
		else if (rx_push_reg && !fifo_in_ready)
			rx_overrun <= 1'b1;
		else if (reset_rise)
			rx_overrun <= 1'b0;
	end

	swr_fifo2 #(.W(8), .DEPTH(2)) u_rx_buf (
		.clk(clk),
		.rst_b(rst_b),
		.in_data(rx_byte_reg),
		.in_valid(rx_push_reg),
		.in_ready(fifo_in_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_cmd_done(logic [7:0] c);
		state_reg == ST_CMD && bit_evt && bit_cnt_reg == BIT_W'(7) && new_byte == c;
	endsequence

	property p_long_clear;
		reset_rise && long_rst |=> !overdrive_flag && state_reg == ST_PDH;
	endproperty
	a_long_clear: assert property (p_long_clear) else $error("long reset kept overdrive"); // see R21

	property p_short_keep;
		reset_rise && !long_rst && overdrive_flag |=> overdrive_flag;
	endproperty
	a_short_keep: assert property (p_short_keep) else $error("short reset dropped overdrive"); // see R13

	property p_od_skip;
		s_cmd_done(CMD_OD_SKIP) |=> overdrive_flag && state_reg == ST_FUNC;
	endproperty
	a_od_skip: assert property (p_od_skip) else $error("overdrive skip not taken"); // see R12

	property p_skip;
		s_cmd_done(CMD_SKIP) |=> state_reg == ST_FUNC ##1 func_active;
	endproperty
	a_skip: assert property (p_skip) else $error("skip did not open function phase"); // see R10

	property p_presence;
		state_reg == ST_PDH && tmr_reg == c_pdh |=> dq_oe && state_reg == ST_PDL;
	endproperty
	a_presence: assert property (p_presence) else $error("presence pulse not started"); // see R20

	property p_match_miss;
		state_reg == ST_MATCH && bit_evt && last_id_bit && !(match_ok_reg && rx_bit == id_bit)
			|=> state_reg == ST_DEAD && overdrive_flag == $past(overdrive_flag);
	endproperty
	a_match_miss: assert property (p_match_miss) else $error("failed match went on"); // see R9

	property p_search_drop;
		state_reg == ST_SEARCH && bit_evt && phase_reg == 2'h2 && rx_bit != id_bit |=> state_reg == ST_DEAD;
	endproperty
	a_search_drop: assert property (p_search_drop) else $error("search kept a losing device"); // see R24

	property p_slot_sync;
		fall_evt && state_reg >= ST_CMD |=> in_slot_reg && tmr_reg == '0;
	endproperty
	a_slot_sync: assert property (p_slot_sync) else $error("slot not tied to falling edge"); // see R5

	// the slot timer doubles as the counter that bounds a slot
	property p_slot_end;
		in_slot_reg |-> tmr_reg <= c_smp;
	endproperty
	a_slot_end: assert property (p_slot_end) else $error("slot ran past its sample point"); // see R22

	property p_drive_only;
		dq_oe |-> !dq_out && (state_reg == ST_PDL || in_slot_reg);
	endproperty
	a_drive_only: assert property (p_drive_only) else $error("line driven outside slot"); // see R4

	property p_func_order;
		$rose(func_active) |-> $past(state_reg == ST_FUNC) && !$past(state_reg == ST_FUNC, 2);
	endproperty
	a_func_order: assert property (p_func_order) else $error("function phase out of order"); // see R1

endmodule // swr_link

// File: logic/swr_pkg.sv
package swr_pkg;

	// ----------------------------------------------------------------
	// clock and conversion
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;

	// least times round up, longest times round down, never below one cycle
	function automatic int least_cyc(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int most_cyc(input int t_ns);
		int c;
		c = t_ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------------------------------
	// line timing, in ns
	// ----------------------------------------------------------------
	localparam int T_RST_REG_NS = 120000;
	localparam int T_RST_OD_NS = 16000;
	localparam int T_RST_LONG_NS = 480000;
	localparam int T_PDH_REG_NS = 30000;
	localparam int T_PDH_OD_NS = 3000;
	localparam int T_PDL_REG_NS = 120000;
	localparam int T_PDL_OD_NS = 16000;
	localparam int T_SMP_REG_NS = 30000;
	localparam int T_SMP_OD_NS = 3000;

	localparam int RST_REG_CYC_DEF = least_cyc(T_RST_REG_NS);
	localparam int RST_OD_CYC = least_cyc(T_RST_OD_NS);
	localparam int RST_LONG_CYC_DEF = least_cyc(T_RST_LONG_NS);
	localparam int PDH_REG_CYC = least_cyc(T_PDH_REG_NS);
	localparam int PDH_OD_CYC = least_cyc(T_PDH_OD_NS);
	localparam int PDL_REG_CYC_DEF = least_cyc(T_PDL_REG_NS);
	localparam int PDL_OD_CYC = least_cyc(T_PDL_OD_NS);
	localparam int SMP_REG_CYC = most_cyc(T_SMP_REG_NS);
	localparam int SMP_OD_CYC = most_cyc(T_SMP_OD_NS);

	localparam int CNT_W = 16;
	localparam int ID_BITS = 64;
	localparam int BIT_W = 7;

	// ----------------------------------------------------------------
	// network commands
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ID = 8'h33;
	localparam logic [7:0] CMD_MATCH = 8'h55;
	localparam logic [7:0] CMD_SKIP = 8'hCC;
	localparam logic [7:0] CMD_SEARCH = 8'hF0;
	localparam logic [7:0] CMD_OD_SKIP = 8'h3C;
	localparam logic [7:0] CMD_OD_MATCH = 8'h69;

	typedef enum logic [3:0] {
		ST_DEAD,
		ST_PDH,
		ST_PDL,
		ST_CMD,
		ST_READ_ID,
		ST_MATCH,
		ST_SEARCH,
		ST_FUNC
	} swr_state_t;

endpackage

// File: test/single_wire_slave_rom_layer_tb.sv
`timescale 1ns/1ps
module single_wire_slave_rom_layer_tb;
	// identity the link carries by default, arbitrary values
	localparam logic [7:0] FAM = 8'h5E;
	localparam logic [47:0] SER = 48'h0123_4567_89AB;
	localparam logic [7:0] CHK = 8'h3D;
	localparam logic [63:0] ID = {CHK, SER, FAM};

	logic clk = 1'h0, rst_b = 1'h0, rx_ready = 1'h0, tx_valid = 1'h0;
	logic [7:0] tx_data = 8'h00, rx_data;
	logic dq_out, dq_oe, overdrive_flag, link_reset, func_active, rx_overrun, rx_valid, tx_taken;
	logic master_pull, dq_line, b, c;
	logic [7:0] byt;
	logic [63:0] v;
	int miscompares = 0, samples_checked = 0, n_lrst = 0, n_tx = 0;

	always #12.5 clk = ~clk;
	assign dq_line = !(master_pull || dq_oe);

	always @(posedge clk) begin
		if (link_reset === 1'h1) n_lrst <= n_lrst + 1;
		if (tx_taken === 1'h1) n_tx <= n_tx + 1;
	end

	swr_master_model M (.clk(clk), .dq(dq_line), .master_pull(master_pull));

	swr_link #(.RST_REG_CYC(2000), .RST_LONG_CYC(4000), .PDL_REG_CYC(400)) DUT (.clk(clk), .rst_b(rst_b),
		.dq_in(dq_line), .dq_out(dq_out),
		.dq_oe(dq_oe), .overdrive_flag(overdrive_flag), .link_reset(link_reset), .func_active(func_active),
		.rx_overrun(rx_overrun), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(tx_taken));

	// ----------------------------------------------------------------
	// compare and closing
	// ----------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_range(input int got, input int lo, input int hi, input string what);
		samples_checked++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("ERROR %0t %s got %0d", $time, what, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic rst_seq(input int low);
		int w, l, n0;
		n0 = n_lrst;
		M.bus_reset(low, w, l);
		chk_val(64'(n_lrst - n0), 64'h1, "reset pulses");
		chk_range(w, M.od ? 80 : 600, M.od ? 240 : 2400, "presence wait");
		chk_range(l, M.od ? 320 : 398, M.od ? 960 : 402, "presence width");
		chk_bit(func_active, 1'h0, "func after reset");
	endtask

	task automatic send_id(input logic [63:0] d);
		for (int i = 0; i < 64; i++) begin
			M.write_bit(d[i]);
		end
	endtask

	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		while (rx_valid !== 1'h1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk_val(64'({rx_valid, rx_data}), 64'({1'h1, exp}), "rx byte");
		@(posedge clk);
		rx_ready <= 1'h1;
		@(posedge clk);
		rx_ready <= 1'h0;
	endtask

	task automatic wait_tx(input int target);
		int n;
		n = 0;
		while (n_tx < target && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk_val(64'(n_tx), 64'(target), "tx taken");
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_dead;
		M.read_bit(b);
		chk_bit(b, 1'h1, "silent before reset");
		chk_bit(dq_out, 1'h0, "open drain level");
		$display("test dead done");
	endtask

	task automatic t_od_skip;
		rst_seq(4400);
		chk_bit(overdrive_flag, 1'h0, "regular after reset");
		M.write_byte(8'h3C);
		chk_bit(overdrive_flag, 1'h1, "od skip sets flag");
		chk_bit(func_active, 1'h1, "od skip to function");
		$display("test od skip done");
	endtask

	task automatic t_read_id;
		M.od = 1'h1;
		rst_seq(800);
		chk_bit(overdrive_flag, 1'h1, "short reset keeps od");
		M.write_byte(8'h33);
		for (int i = 0; i < 64; i++) begin
			M.read_bit(v[i]);
		end
		chk_val(v, ID, "identity");
		$display("test read id done");
	endtask

	task automatic t_func;
		rst_seq(800);
		M.write_byte(8'hCC);
		chk_bit(func_active, 1'h1, "skip to function");
		M.write_byte(8'h0F);
		M.write_byte(8'h26);
		M.write_byte(8'h00);
		chk_bit(rx_overrun, 1'h1, "third byte overruns");
		pop(8'h0F);
		pop(8'h26);
		@(negedge clk);
		chk_bit(rx_valid, 1'h0, "buffer drained");
		@(posedge clk);
		tx_data <= 8'h26;
		tx_valid <= 1'h1;
		wait_tx(1);
		@(posedge clk);
		tx_data <= 8'h07;
		M.read_byte(byt);
		chk_val(64'(byt), 64'h26, "tx first");
		wait_tx(2);
		@(posedge clk);
		tx_valid <= 1'h0;
		M.read_byte(byt);
		chk_val(64'(byt), 64'h07, "tx second");
		$display("test function bytes done");
	endtask

	task automatic t_match;
		rst_seq(800);
		M.write_byte(8'h55);
		send_id(ID);
		chk_bit(func_active, 1'h1, "match accepted");
		rst_seq(800);
		M.write_byte(8'h55);
		send_id(ID ^ 64'h8000_0000_0000_0000);
		chk_bit(func_active, 1'h0, "mismatch refused");
		M.read_bit(b);
		chk_bit(b, 1'h1, "mismatch silent");
		$display("test match done");
	endtask

	task automatic t_search;
		rst_seq(800);
		M.write_byte(8'hF0);
		for (int i = 0; i < 5; i++) begin
			M.read_bit(b);
			M.read_bit(c);
			chk_val(64'({b, c}), 64'({ID[i], ~ID[i]}), "search pair");
			M.write_bit(i == 4 ? ~ID[i] : ID[i]);
		end
		M.read_bit(b);
		M.read_bit(c);
		chk_val(64'({b, c}), 64'h3, "dropped from search");
		$display("test search done");
	endtask

	task automatic t_od_match;
		M.od = 1'h0;
		rst_seq(4400);
		chk_bit(overdrive_flag, 1'h0, "long reset clears od");
		M.write_byte(8'h69);
		M.od = 1'h1;
		send_id(ID);
		chk_bit(overdrive_flag, 1'h1, "od match sets flag");
		chk_bit(func_active, 1'h1, "od match to function");
		$display("test od match done");
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		t_dead();
		t_od_skip();
		t_read_id();
		t_func();
		t_match();
		t_search();
		t_od_match();
		report_and_stop();
	end

	// whole run needs about 92k cycles
	initial begin
		repeat (98000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule // single_wire_slave_rom_layer_tb

// File: test/swr_master_model.sv
`timescale 1ns/1ps
module swr_master_model (
	// clock
	input wire logic clk,
	// shared line
	input wire logic dq,
	output logic master_pull
);
	logic od = 1'h0;
	initial master_pull = 1'h0;

	task automatic hold(input logic p, input int n);
		master_pull <= p;
		repeat (n) @(posedge clk);
	endtask

	// low below the reset limit, slot long enough for the sample point
	task automatic write_bit(input logic b);
		int lo;
		lo = b ? (od ? 10 : 40) : (od ? 130 : 1250);
		hold(1'h1, lo);
		hold(1'h0, (od ? 140 : 1300) - lo);
	endtask

	task automatic read_bit(output logic b);
		hold(1'h1, od ? 4 : 40);
		hold(1'h0, od ? 55 : 559);
		@(negedge clk);
		b = dq;
		repeat (od ? 80 : 640) @(posedge clk);
	endtask

	task automatic write_byte(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			write_bit(d[i]);
		end
	endtask

	task automatic read_byte(output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			read_bit(d[i]);
		end
	endtask

	// line left high after release, so presence is the device's own pull
	task automatic bus_reset(input int low, output int pwait, output int plen);
		pwait = 0;
		plen = 0;
		hold(1'h1, low);
		hold(1'h0, 1);
		while (dq !== 1'h0 && pwait < 3000) begin
			@(negedge clk);
			pwait++;
		end
		while (dq === 1'h0 && plen < 6000) begin
			@(negedge clk);
			plen++;
		end
		repeat (od ? 20 : 100) @(posedge clk);
	endtask
endmodule // swr_master_model
